// ---- hw/adcc_top.v ----
// Converter control block: AXI4-Lite registers, port configuration, sequencing and interrupt
`timescale 1ns/100ps
`include "adcc_defines.vh"

module adcc_top #(
  parameter CONV_TICKS = `ADCC_CONV_TICKS,
  parameter RES_W = 10,
  parameter LINES = 8
) (
  input wire aclk,
  input wire aresetn,
  input wire ce,
  input wire [7:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [RES_W-1:0] core_data,
  output wire [2:0] core_channel,
  output wire core_power_on,
  output wire core_clk_tick,
  output wire core_reset,
  output wire core_start,
  output wire [LINES-1:0] line_analog_en,
  output wire [LINES-1:0] line_digital_off,
  output wire [LINES-1:0] line_pullup_off,
  output wire irq
);

  // ==================================================
  // State
  reg [2:0] ch_reg;
  reg [2:0] pcfg_reg;
  reg eoc_reg;
  reg start_reg;
  reg [1:0] div_reg;
  reg test_reg;
  reg [RES_W-1:0] result_reg;
  reg int_stat_reg;
  reg int_mask_reg;
  reg aw_got_reg;
  reg [7:0] aw_addr_reg;
  reg w_got_reg;
  reg [7:0] w_data_reg;
  reg w_strb_reg;
  reg [7:0] rd_byte;
  reg rd_hit;

  wire aw_take;
  wire w_take;
  wire ar_take;
  wire wr_do;
  wire [7:0] wr_idx;
  wire [7:0] rd_idx;
  wire wr_hit;
  wire wr_ctl;
  wire wr_csel;
  wire wr_stat;
  wire wr_mask;
  wire new_start;
  wire start_rise;
  wire start_fall;
  wire conv_done;

  // ==================================================
  // AXI4-Lite handshakes
  // Address and data are latched independently; one write is answered at a time
  assign s_axi_awready = ce & ~aw_got_reg & ~s_axi_bvalid;
  assign s_axi_wready = ce & ~w_got_reg & ~s_axi_bvalid;
  assign s_axi_arready = ce & ~s_axi_rvalid;
  assign aw_take = s_axi_awvalid & s_axi_awready;
  assign w_take = s_axi_wvalid & s_axi_wready;
  assign ar_take = s_axi_arvalid & s_axi_arready;
  assign wr_do = aw_got_reg & w_got_reg & ~s_axi_bvalid;

  assign wr_idx = {2'h0, aw_addr_reg[7:2]};
  assign rd_idx = {2'h0, s_axi_araddr[7:2]};
  assign wr_hit = (wr_idx == `ADCC_IDX_RES_LOW) | (wr_idx == `ADCC_IDX_RES_HIGH) |
                  (wr_idx == `ADCC_IDX_CTL) | (wr_idx == `ADCC_IDX_CSEL) |
                  (wr_idx == `ADCC_IDX_INT_STAT) | (wr_idx == `ADCC_IDX_INT_MASK);
  // Only byte lane 0 carries register bits; other lanes are ignored
  assign wr_ctl = wr_do & w_strb_reg & (wr_idx == `ADCC_IDX_CTL);
  assign wr_csel = wr_do & w_strb_reg & (wr_idx == `ADCC_IDX_CSEL);
  assign wr_stat = wr_do & w_strb_reg & (wr_idx == `ADCC_IDX_INT_STAT);
  assign wr_mask = wr_do & w_strb_reg & (wr_idx == `ADCC_IDX_INT_MASK);

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_got_reg <= 1'b0;
      w_data_reg <= 8'h00;
      w_strb_reg <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `ADCC_RESP_OKAY;
    end
    else if (ce)
    begin
      if (aw_take)
      begin
        aw_got_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (w_take)
      begin
        w_got_reg <= 1'b1;
        w_data_reg <= s_axi_wdata[7:0];
        w_strb_reg <= s_axi_wstrb[0];
      end
      if (wr_do)
      begin
        aw_got_reg <= 1'b0;
        w_got_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `ADCC_RESP_OKAY : `ADCC_RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // ==================================================
  // Control and clock select registers
  assign new_start = w_data_reg[`ADCC_CTL_START_BIT];
  assign start_rise = wr_ctl & ~start_reg & new_start;
  assign start_fall = wr_ctl & start_reg & ~new_start;

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ch_reg <= `ADCC_RST_CH;
      pcfg_reg <= `ADCC_RST_PCFG;
      start_reg <= 1'b0;
      eoc_reg <= 1'b0;
      div_reg <= `ADCC_RST_DIV;
      test_reg <= 1'b0;
    end
    else if (ce)
    begin
      if (wr_ctl)
      begin
        ch_reg <= w_data_reg[`ADCC_CTL_CH_MSB:`ADCC_CTL_CH_LSB];
        pcfg_reg <= w_data_reg[`ADCC_CTL_PCFG_MSB:`ADCC_CTL_PCFG_LSB];
        start_reg <= new_start;
      end
      // A new start edge beats a completion landing in the same cycle
      if (start_rise)
        eoc_reg <= 1'b1;
      else if (conv_done)
        eoc_reg <= 1'b0;
      if (wr_csel)
      begin
        div_reg <= w_data_reg[`ADCC_CSEL_DIV_MSB:`ADCC_CSEL_DIV_LSB];
        // Test bit is stored for read-back only and drives nothing
        test_reg <= w_data_reg[`ADCC_CSEL_TEST_BIT];
      end
    end
  end

  // ==================================================
  // Result capture and interrupt
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      result_reg <= `ADCC_RST_RESULT;
      int_stat_reg <= 1'b0;
      int_mask_reg <= `ADCC_RST_MASK;
    end
    else if (ce)
    begin
      if (conv_done)
        result_reg <= core_data;
      // Set wins over a write-one-to-clear in the same cycle
      if (conv_done)
        int_stat_reg <= 1'b1;
      else if (wr_stat && w_data_reg[`ADCC_INT_DONE_BIT])
        int_stat_reg <= 1'b0;
      if (wr_mask)
        int_mask_reg <= w_data_reg[`ADCC_INT_DONE_BIT];
    end
  end

  assign irq = int_stat_reg & int_mask_reg;

  // ==================================================
  // Read path
  always @*
  begin
    rd_byte = 8'h00;
    rd_hit = 1'b1;
    case (rd_idx)
      `ADCC_IDX_RES_LOW: rd_byte = {result_reg[1:0], 6'h00};
      `ADCC_IDX_RES_HIGH: rd_byte = result_reg[RES_W-1:2];
      `ADCC_IDX_CTL: rd_byte = {start_reg, eoc_reg, pcfg_reg, ch_reg};
      `ADCC_IDX_CSEL: rd_byte = {test_reg, 5'h00, div_reg};
      `ADCC_IDX_INT_STAT: rd_byte = {7'h00, int_stat_reg};
      `ADCC_IDX_INT_MASK: rd_byte = {7'h00, int_mask_reg};
      default: rd_hit = 1'b0;
    endcase
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `ADCC_RESP_OKAY;
    end
    else if (ce)
    begin
      if (ar_take)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h000000, rd_byte};
        s_axi_rresp <= rd_hit ? `ADCC_RESP_OKAY : `ADCC_RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // ==================================================
  // Port line configuration and power
  genvar gi;
  generate
    for (gi = 0; gi < LINES; gi = gi + 1)
    begin : g_line
      // Code 7 jumps from six lines straight to all eight; no code gives seven
      assign line_analog_en[gi] = (pcfg_reg == `ADCC_PCFG_ALL) | (gi < pcfg_reg);
      assign line_digital_off[gi] = line_analog_en[gi];
      assign line_pullup_off[gi] = line_analog_en[gi];
    end
  endgenerate

  assign core_power_on = (pcfg_reg != `ADCC_PCFG_OFF);
  assign core_channel = ch_reg;

  // ==================================================
  // Converter clock and sequencer
  adcc_clkdiv u_clkdiv (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .div_sel(div_reg),
    .tick(core_clk_tick)
  );

  // Completion relies on software keeping start low during the conversion
  adcc_seq #(
    .TICKS(CONV_TICKS)
  ) u_seq (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .start_rise(start_rise),
    .start_fall(start_fall),
    .tick(core_clk_tick),
    .core_reset(core_reset),
    .core_start(core_start),
    .done(conv_done)
  );

endmodule

// ---- hw/adcc_defines.vh ----
// Register map, field positions, reset values and timing counts of the converter control block
`ifndef ADCC_DEFINES_VH
`define ADCC_DEFINES_VH

// ==================================================
// Register indices; byte address is four times the index
`define ADCC_IDX_RES_LOW 8'h24
`define ADCC_IDX_RES_HIGH 8'h25
`define ADCC_IDX_CTL 8'h26
`define ADCC_IDX_CSEL 8'h27
`define ADCC_IDX_INT_STAT 8'h28
`define ADCC_IDX_INT_MASK 8'h29

// ==================================================
// Control register fields
`define ADCC_CTL_CH_LSB 0
`define ADCC_CTL_CH_MSB 2
`define ADCC_CTL_PCFG_LSB 3
`define ADCC_CTL_PCFG_MSB 5
`define ADCC_CTL_EOC_BIT 6
`define ADCC_CTL_START_BIT 7
`define ADCC_PCFG_OFF 3'h0
`define ADCC_PCFG_ALL 3'h7

// ==================================================
// Clock select fields and divider codes
`define ADCC_CSEL_DIV_LSB 0
`define ADCC_CSEL_DIV_MSB 1
`define ADCC_CSEL_TEST_BIT 7
`define ADCC_DIV_2 2'h0
`define ADCC_DIV_8 2'h1
`define ADCC_DIV_32 2'h2
`define ADCC_LIM_2 5'h01
`define ADCC_LIM_8 5'h07
`define ADCC_LIM_32 5'h1F

// ==================================================
// Reset values
`define ADCC_RST_CH 3'h0
`define ADCC_RST_PCFG 3'h0
`define ADCC_RST_DIV 2'h0
`define ADCC_RST_RESULT 10'h000
`define ADCC_RST_MASK 1'h0

// ==================================================
// Interrupt bit, bus responses, timing
`define ADCC_INT_DONE_BIT 0
`define ADCC_RESP_OKAY 2'h0
`define ADCC_RESP_SLVERR 2'h2
`define ADCC_CONV_TICKS 16

`endif

// ---- hw/adcc_clkdiv.v ----
// Converter clock divider: one-cycle tick every 2, 8 or 32 system clocks
`timescale 1ns/100ps
`include "adcc_defines.vh"

module adcc_clkdiv (
  input wire aclk,
  input wire aresetn,
  input wire ce,
  input wire [1:0] div_sel,
  output reg tick
);

  reg [4:0] cnt_reg;
  reg [4:0] limit;
  reg sel_ok;

  // ==================================================
  // Divider
  always @*
  begin
    limit = `ADCC_LIM_32;
    sel_ok = 1'b1;
    case (div_sel)
      `ADCC_DIV_2: limit = `ADCC_LIM_2;
      `ADCC_DIV_8: limit = `ADCC_LIM_8;
      `ADCC_DIV_32: limit = `ADCC_LIM_32;
      // Undefined code: the converter clock stops rather than guess a rate
      default: sel_ok = 1'b0;
    endcase
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_reg <= 5'h00;
      tick <= 1'b0;
    end
    else if (ce)
    begin
      // Wrap also covers a switch to a smaller divider mid-count
      if (!sel_ok || cnt_reg >= limit)
        cnt_reg <= 5'h00;
      else
        cnt_reg <= cnt_reg + 5'h01;
      tick <= sel_ok && (cnt_reg >= limit);
    end
  end

endmodule

// ---- hw/adcc_seq.v ----
// Conversion sequencer: reset hold, start and fixed-length conversion count
`timescale 1ns/100ps
`include "adcc_defines.vh"

module adcc_seq #(
  parameter TICKS = `ADCC_CONV_TICKS,
  parameter CNT_W = 8
) (
  input wire aclk,
  input wire aresetn,
  input wire ce,
  input wire start_rise,
  input wire start_fall,
  input wire tick,
  output reg core_reset,
  output reg core_start,
  output reg done
);

  localparam ST_IDLE = 2'h0;
  localparam ST_HOLD = 2'h1;
  localparam ST_CONV = 2'h2;
  localparam integer LAST_I = TICKS - 1;
  localparam [CNT_W-1:0] LAST = LAST_I[CNT_W-1:0];

  reg [1:0] state_reg;
  reg [CNT_W-1:0] cnt_reg;

  // ==================================================
  // State machine
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_reg <= ST_IDLE;
      cnt_reg <= {CNT_W{1'b0}};
      core_reset <= 1'b0;
      core_start <= 1'b0;
      done <= 1'b0;
    end
    else if (ce)
    begin
      core_start <= 1'b0;
      done <= 1'b0;
      // A rising start always wins, even over a conversion about to finish
      if (start_rise)
      begin
        state_reg <= ST_HOLD;
        core_reset <= 1'b1;
        cnt_reg <= {CNT_W{1'b0}};
      end
      else
      begin
        case (state_reg)
          ST_HOLD:
          begin
            if (start_fall)
            begin
              state_reg <= ST_CONV;
              core_reset <= 1'b0;
              core_start <= 1'b1;
            end
          end
          ST_CONV:
          begin
            if (tick)
            begin
              if (cnt_reg == LAST)
              begin
                state_reg <= ST_IDLE;
                cnt_reg <= {CNT_W{1'b0}};
                done <= 1'b1;
              end
              else
                cnt_reg <= cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
            end
          end
          ST_IDLE:
            core_reset <= 1'b0;
          default:
          begin
            state_reg <= ST_IDLE;
            core_reset <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule

// ---- hw/adcc_top_unused_placeholder_removed.v ----
// Shared timescale for the converter control block sources
`timescale 1ns/100ps

// ---- tb/adcc_top_assertions.sv ----
// Port-level assertion checker for the converter control block
`timescale 1ns/100ps
module adcc_checker (
  input wire aclk,
  input wire aresetn,
  input wire ce,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_bvalid,
  input wire core_clk_tick,
  input wire core_reset,
  input wire core_start,
  input wire core_power_on,
  input wire [7:0] line_analog_en,
  input wire [7:0] line_digital_off,
  input wire [7:0] line_pullup_off,
  input wire irq
);
  // ==========
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  power_follows_lines_a: assert property (core_power_on == (line_analog_en != 8'h00))
    else $error("power and analog lines disagree");
  lines_alike_a: assert property ({line_digital_off, line_pullup_off} == {2{line_analog_en}})
    else $error("line controls differ");
  lines_prefix_a: assert property ((line_analog_en & (line_analog_en + 8'h01)) == 8'h00 && line_analog_en != 8'h7F)
    else $error("analog lines not a low prefix");
  tick_pulse_a: assert property (core_clk_tick && ce |=> !core_clk_tick)
    else $error("tick longer than one cycle");
  start_pulse_a: assert property (core_start && ce |-> !core_reset ##1 !core_start)
    else $error("start pulse malformed");
  hold_release_a: assert property ($fell(core_reset) |-> ##[0:1] core_start)
    else $error("reset release without start");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  read_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("read upper bits set");
  irq_fall_a: assert property ($fell(irq) |-> $rose(s_axi_bvalid))
    else $error("irq dropped without a write");
endmodule

bind adcc_top adcc_checker u_adcc_checker (.aclk, .aresetn, .ce, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready, .s_axi_rdata, .s_axi_bvalid, .core_clk_tick, .core_reset, .core_start, .core_power_on,
  .line_analog_en, .line_digital_off, .line_pullup_off, .irq);

// ---- tb/test_adc_conversion_control.sv ----
// Self-checking bench for the converter control block
`timescale 1ns/100ps
`include "adcc_defines.vh"
module test_adc_conversion_control;
  // ==========
  // Signals
  localparam int TICKS = 4;
  localparam logic [1:0] OK = `ADCC_RESP_OKAY;
  localparam logic [1:0] SE = `ADCC_RESP_SLVERR;
  logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0, core_channel;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, core_power_on, core_clk_tick;
  logic core_reset, core_start, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [9:0] core_data = 10'h000;
  logic [7:0] line_analog_en, line_digital_off, line_pullup_off;
  int fail_count = 0, total_checks = 0, cycles = 0, tick_cnt = 0;

  adcc_top #(.CONV_TICKS(TICKS)) u_adcc_top (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awprot,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .core_data, .core_channel, .core_power_on, .core_clk_tick,
    .core_reset, .core_start, .line_analog_en, .line_digital_off, .line_pullup_off, .irq);

  initial forever #2.5 aclk = ~aclk;

  task automatic conclude();
    if (fail_count == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Hang guard; the full run needs only a few hundred cycles
  always @(posedge aclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      fail_count++;
      conclude();
    end
  end

  // Ticks since the conversion start pulse, one landing with it included, frozen once the interrupt is up
  always @(posedge aclk)
  begin
    if (core_start === 1'b1) tick_cnt <= (core_clk_tick === 1'b1) ? 1 : 0;
    else if (core_clk_tick === 1'b1 && irq !== 1'b1) tick_cnt <= tick_cnt + 1;
  end

  // ==========
  // Bus tasks
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask

  // Ready is looked at between edges, so the handshake edge is known without a race
  task automatic wr(input logic [7:0] idx, input logic [7:0] data, output logic [1:0] resp);
    logic ad, wd;
    @(posedge aclk);
    s_axi_awaddr <= idx << 2;
    s_axi_wdata <= {24'h000000, data};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    ad = 1'b0;
    wd = 1'b0;
    do
    begin
      @(negedge aclk);
      ad = ad | (s_axi_awvalid & s_axi_awready);
      wd = wd | (s_axi_wvalid & s_axi_wready);
      @(posedge aclk);
      if (ad) s_axi_awvalid <= 1'b0;
      if (wd) s_axi_wvalid <= 1'b0;
    end while (!(ad && wd));
    do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] idx, output logic [31:0] data, output logic [1:0] resp);
    @(posedge aclk);
    s_axi_araddr <= idx << 2;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge aclk); while (s_axi_arready !== 1'b1);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
    data = s_axi_rdata;
    resp = s_axi_rresp;
    @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask

  task automatic rx(input logic [7:0] idx, input logic [31:0] exp, input logic [1:0] er, input string name);
    logic [31:0] d;
    logic [1:0] r;
    rd(idx, d, r);
    check(name, exp, d);
    check({name, "_resp"}, {30'h0, er}, {30'h0, r});
  endtask

  task automatic wx(input logic [7:0] idx, input logic [7:0] data, input logic [1:0] er);
    logic [1:0] r;
    wr(idx, data, r);
    check("bresp", {30'h0, er}, {30'h0, r});
  endtask

  task automatic tick_gap(output int n);
    do @(negedge aclk); while (core_clk_tick !== 1'b1);
    n = 0;
    do
    begin
      @(negedge aclk);
      n++;
    end while (core_clk_tick !== 1'b1);
  endtask

  // ==========
  // Tests
  initial
  begin
    int g;
    logic [7:0] e;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rx(`ADCC_IDX_CTL, 32'h0, OK, "ctl_rst");
    rx(`ADCC_IDX_RES_HIGH, 32'h0, OK, "res_rst");
    rx(8'h00, 32'h0, SE, "unmapped");
    wx(8'h3F, 8'h55, SE);
    wx(`ADCC_IDX_CSEL, 8'h7F, OK);
    rx(`ADCC_IDX_CSEL, 32'h3, OK, "csel_unused");
    for (int c = 0; c < 3; c++)
    begin
      wx(`ADCC_IDX_CSEL, 8'(c), OK);
      tick_gap(g);
      check("tick_gap", 2 << (2 * c), g);
    end
    for (int p = 0; p < 8; p++)
    begin
      e = (p == 7) ? 8'hFF : 8'((1 << p) - 1);
      wx(`ADCC_IDX_CTL, 8'(p * 8 + 7 - p), OK);
      check("channel", 7 - p, core_channel);
      check("lines", e, line_analog_en);
      check("io_off", {e, e}, {line_pullup_off, line_digital_off});
      check("power", p != 0, core_power_on);
      rx(`ADCC_IDX_CTL, p * 8 + 7 - p, OK, "ctl_rb");
    end
    wx(`ADCC_IDX_INT_MASK, 8'h01, OK);
    wx(`ADCC_IDX_CSEL, 8'h01, OK);
    core_data <= 10'h2D5;
    wx(`ADCC_IDX_CTL, 8'hA3, OK);
    rx(`ADCC_IDX_CTL, 32'hE3, OK, "eoc_set");
    repeat (40) @(posedge aclk);
    check("held", 1, core_reset);
    rx(`ADCC_IDX_INT_STAT, 32'h0, OK, "no_done");
    wx(`ADCC_IDX_CTL, 8'h23, OK);
    rx(`ADCC_IDX_CTL, 32'h63, OK, "eoc_busy");
    while (irq !== 1'b1) @(negedge aclk);
    check("conv_ticks", TICKS, tick_cnt);
    rx(`ADCC_IDX_CTL, 32'h23, OK, "eoc_clear");
    rx(`ADCC_IDX_RES_LOW, 32'h40, OK, "res_low");
    rx(`ADCC_IDX_RES_HIGH, 32'hB5, OK, "res_high");
    wx(`ADCC_IDX_RES_LOW, 8'hFF, OK);
    rx(`ADCC_IDX_RES_LOW, 32'h40, OK, "res_ro");
    rx(`ADCC_IDX_INT_STAT, 32'h1, OK, "stat_set");
    wx(`ADCC_IDX_INT_MASK, 8'h00, OK);
    check("irq_masked", 0, irq);
    wx(`ADCC_IDX_INT_MASK, 8'h01, OK);
    check("irq_unmasked", 1, irq);
    wx(`ADCC_IDX_INT_STAT, 8'h01, OK);
    check("irq_cleared", 0, irq);
    rx(`ADCC_IDX_INT_STAT, 32'h0, OK, "stat_clr");
    // Lane 0 strobe low: answered but ignored
    s_axi_wstrb <= 4'hE;
    wx(`ADCC_IDX_CTL, 8'h07, OK);
    s_axi_wstrb <= 4'hF;
    rx(`ADCC_IDX_CTL, 32'h23, OK, "strb_off");
    conclude();
  end
endmodule
